// file: shared/cfq_pkg.sv
/*
 * cfq_pkg: constants for the query database readout block.
 * Assumes a 16-bit data bus addressed in words; no other package needed.
 */
package cfq_pkg;

    localparam int          CFQ_ADDR_W      = 8;     // word address bits seen
    localparam int          CFQ_DATA_W      = 16;    // device bus width
    localparam logic [15:0] CFQ_RST_DATA    = 16'h0000;

    // query space partition
    localparam logic [7:0]  CFQ_OFS_ID      = 8'h10; // id string start
    localparam logic [7:0]  CFQ_OFS_SYS     = 8'h1B; // system interface
    localparam logic [7:0]  CFQ_OFS_GEO     = 8'h27; // geometry (elsewhere)

    // id string
    localparam logic [7:0]  CFQ_OFS_SIG0    = 8'h10;
    localparam logic [7:0]  CFQ_OFS_SIG1    = 8'h11;
    localparam logic [7:0]  CFQ_OFS_SIG2    = 8'h12;
    localparam logic [7:0]  CFQ_OFS_PRI_LO  = 8'h13;
    localparam logic [7:0]  CFQ_OFS_PRI_HI  = 8'h14;
    localparam logic [7:0]  CFQ_OFS_EXT_LO  = 8'h15;
    localparam logic [7:0]  CFQ_OFS_EXT_HI  = 8'h16;
    localparam logic [7:0]  CFQ_OFS_ALT_LO  = 8'h17;
    localparam logic [7:0]  CFQ_OFS_ALT_HI  = 8'h18;
    localparam logic [7:0]  CFQ_OFS_SEC_LO  = 8'h19;
    localparam logic [7:0]  CFQ_OFS_SEC_HI  = 8'h1A;
    // system interface
    localparam logic [7:0]  CFQ_OFS_VCC_MIN = 8'h1B;
    localparam logic [7:0]  CFQ_OFS_VCC_MAX = 8'h1C;
    localparam logic [7:0]  CFQ_OFS_VPP_MIN = 8'h1D;
    localparam logic [7:0]  CFQ_OFS_VPP_MAX = 8'h1E;
    localparam logic [7:0]  CFQ_OFS_TW_TYP  = 8'h1F;
    localparam logic [7:0]  CFQ_OFS_TB_TYP  = 8'h20;
    localparam logic [7:0]  CFQ_OFS_TE_TYP  = 8'h21;
    localparam logic [7:0]  CFQ_OFS_TC_TYP  = 8'h22;
    localparam logic [7:0]  CFQ_OFS_TW_MAX  = 8'h23;
    localparam logic [7:0]  CFQ_OFS_TB_MAX  = 8'h24;
    localparam logic [7:0]  CFQ_OFS_TE_MAX  = 8'h25;
    localparam logic [7:0]  CFQ_OFS_TC_MAX  = 8'h26;

    // data values
    localparam logic [7:0]  CFQ_VAL_SIG0    = 8'h51;
    localparam logic [7:0]  CFQ_VAL_SIG1    = 8'h52;
    localparam logic [7:0]  CFQ_VAL_SIG2    = 8'h59;
    localparam logic [7:0]  CFQ_VAL_EXT_LO  = 8'h0A;
    localparam logic [7:0]  CFQ_VAL_EXT_HI  = 8'h01;
    localparam logic [7:0]  CFQ_VAL_NONE    = 8'h00;
    localparam logic [7:0]  CFQ_VAL_VCC_MIN = 8'h17;
    localparam logic [7:0]  CFQ_VAL_VCC_MAX = 8'h20;
    localparam logic [7:0]  CFQ_VAL_VPP_MIN = 8'h85;
    localparam logic [7:0]  CFQ_VAL_VPP_MAX = 8'h95;
    localparam logic [7:0]  CFQ_VAL_TW_TYP  = 8'h06;
    localparam logic [7:0]  CFQ_VAL_TB_BIG  = 8'h0B;
    localparam logic [7:0]  CFQ_VAL_TB_SML  = 8'h0A;
    localparam logic [7:0]  CFQ_VAL_TE_TYP  = 8'h0A;
    localparam logic [7:0]  CFQ_VAL_TW_MAX  = 8'h02;
    localparam logic [7:0]  CFQ_VAL_TBM_BIG = 8'h01;
    localparam logic [7:0]  CFQ_VAL_TBM_SML = 8'h02;
    localparam logic [7:0]  CFQ_VAL_TE_MAX  = 8'h02;

endpackage : cfq_pkg

// file: src/cfq_readout.sv
/*
 * cfq_readout: query database readout of a 16-bit flash device.
 * Assumes the command decoder raises i_query_mode after the query command,
 * and that the array path delivers i_array_data on the same clock.
 * Address and mode come from same-clock logic, so no synchronisers.
 */
`timescale 1ns/1ps

module cfq_readout
#(
    parameter logic [15:0] PRIMARY_COMMAND_SET_CODE = 16'h0001, // arbitrary
    parameter bit          LARGEST_DENSITY          = 1'b0
)
(
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rst,
    input  wire logic                           i_query_mode,
    input  wire logic                           i_rd_req,
    input  wire logic [cfq_pkg::CFQ_ADDR_W-1:0] i_word_addr,
    input  wire logic [cfq_pkg::CFQ_DATA_W-1:0] i_array_data,
    output logic      [cfq_pkg::CFQ_DATA_W-1:0] o_rd_data,
    output logic                                o_rd_valid,
    output logic                                o_in_query
);
    import cfq_pkg::*;

    // state of the readout path
    typedef enum logic [1:0]
    {
        CFQ_IDLE = 2'b01,
        CFQ_SERV = 2'b10
    } cfq_state_t;

    cfq_state_t                 state_reg;     // readout phase
    cfq_state_t                 state_next;
    logic [CFQ_DATA_W-1:0]      data_reg;      // answer word
    logic [CFQ_DATA_W-1:0]      data_next;
    logic                       valid_reg;     // answer strobe
    logic                       inq_reg;       // mode mirror

    wire  [7:0]                 query_byte;    // table lookup result
    wire  [CFQ_DATA_W-1:0]      query_word;    // zero-extended byte
    wire                        in_id;         // id section hit
    wire                        in_sys;        // system section hit
    wire  [7:0]                 tb_typ;        // density-chosen values
    wire  [7:0]                 tb_max;

    // partition decode, geometry and vendor space read zero here
    assign in_id  = (i_word_addr >= CFQ_OFS_ID)
                 && (i_word_addr <  CFQ_OFS_SYS);
    assign in_sys = (i_word_addr >= CFQ_OFS_SYS)
                 && (i_word_addr <  CFQ_OFS_GEO);

    // density-dependent buffer write timing
    assign tb_typ = LARGEST_DENSITY ? CFQ_VAL_TB_BIG
                                    : CFQ_VAL_TB_SML;
    assign tb_max = LARGEST_DENSITY ? CFQ_VAL_TBM_BIG
                                    : CFQ_VAL_TBM_SML;

    // table lookup, one byte per word offset
    function automatic logic [7:0] cfq_lookup(input logic [7:0] ofs);
        logic [7:0] v;
        v = CFQ_VAL_NONE;
        case (ofs)
            CFQ_OFS_SIG0:    v = CFQ_VAL_SIG0;
            CFQ_OFS_SIG1:    v = CFQ_VAL_SIG1;
            CFQ_OFS_SIG2:    v = CFQ_VAL_SIG2;
            CFQ_OFS_PRI_LO:  v = PRIMARY_COMMAND_SET_CODE[7:0];
            CFQ_OFS_PRI_HI:  v = PRIMARY_COMMAND_SET_CODE[15:8];
            CFQ_OFS_EXT_LO:  v = CFQ_VAL_EXT_LO;
            CFQ_OFS_EXT_HI:  v = CFQ_VAL_EXT_HI;
            CFQ_OFS_ALT_LO:  v = CFQ_VAL_NONE;
            CFQ_OFS_ALT_HI:  v = CFQ_VAL_NONE;
            CFQ_OFS_SEC_LO:  v = CFQ_VAL_NONE;
            CFQ_OFS_SEC_HI:  v = CFQ_VAL_NONE;
            CFQ_OFS_VCC_MIN: v = CFQ_VAL_VCC_MIN;
            CFQ_OFS_VCC_MAX: v = CFQ_VAL_VCC_MAX;
            CFQ_OFS_VPP_MIN: v = CFQ_VAL_VPP_MIN;
            CFQ_OFS_VPP_MAX: v = CFQ_VAL_VPP_MAX;
            CFQ_OFS_TW_TYP:  v = CFQ_VAL_TW_TYP;
            CFQ_OFS_TE_TYP:  v = CFQ_VAL_TE_TYP;
            CFQ_OFS_TC_TYP:  v = CFQ_VAL_NONE;
            CFQ_OFS_TW_MAX:  v = CFQ_VAL_TW_MAX;
            CFQ_OFS_TE_MAX:  v = CFQ_VAL_TE_MAX;
            CFQ_OFS_TC_MAX:  v = CFQ_VAL_NONE;
            default:         v = CFQ_VAL_NONE;
        endcase
        return v;
    endfunction : cfq_lookup

    // density entries come from wires, so they sit outside the function
    assign query_byte = (i_word_addr == CFQ_OFS_TB_TYP) ? tb_typ
                      : (i_word_addr == CFQ_OFS_TB_MAX) ? tb_max
                      : (in_id || in_sys) ? cfq_lookup(i_word_addr)
                      : CFQ_VAL_NONE;
    // byte on low lanes, upper lanes forced to zero
    assign query_word = {8'h00, query_byte};

    // next-state and answer selection
    always_comb
    begin
        state_next = state_reg;
        data_next  = data_reg;
        case (state_reg)
            CFQ_IDLE:
            begin
                // query data only once the mode is entered
                if (i_rd_req && i_query_mode)
                begin
                    state_next = CFQ_SERV;
                    data_next  = query_word;
                end
                else if (i_rd_req)
                begin
                    data_next  = i_array_data;
                end
            end
            CFQ_SERV:
            begin
                // leaving the mode drops back to array reads at once
                if (!i_query_mode)
                begin
                    state_next = CFQ_IDLE;
                end
                if (i_rd_req)
                begin
                    data_next = i_query_mode ? query_word
                                             : i_array_data;
                end
            end
            default:
            begin
                state_next = CFQ_IDLE;
            end
        endcase
    end

    // answer registers, one cycle latency per read
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= CFQ_IDLE;
            data_reg  <= CFQ_RST_DATA;
            valid_reg <= 1'b0;
            inq_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            data_reg  <= data_next;
            valid_reg <= i_rd_req;
            inq_reg   <= i_query_mode;
        end
    end

    assign o_rd_data  = data_reg;
    assign o_rd_valid = valid_reg;
    assign o_in_query = inq_reg;

endmodule : cfq_readout

// file: verif/cfq_readout_assertions.sv
/* cfq_readout_chk: port-level checks of the query readout block.
   Assumes one clock domain and the answer one clock after a taken read. */
`timescale 1ns/1ps
module cfq_readout_chk
#(
    parameter logic [15:0] PRIMARY_COMMAND_SET_CODE = 16'h0001,
    parameter bit          LARGEST_DENSITY          = 1'b0
)
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_query_mode,
    input wire logic        i_rd_req,
    input wire logic [7:0]  i_word_addr,
    input wire logic [15:0] i_array_data,
    input wire logic [15:0] o_rd_data,
    input wire logic        o_rd_valid,
    input wire logic        o_in_query
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire       q_rd = i_rd_req && i_query_mode; // query read taken
    wire [7:0] a    = i_word_addr;              // short alias
    AST_PULSE: assert property (i_rd_req |=> o_rd_valid)
        else $error("no answer pulse");
    AST_UPPER_ZERO: assert property (q_rd |=> o_rd_data[15:8] == 8'h00)
        else $error("upper byte not zero");
    AST_SIGNATURE: assert property (q_rd && a == 8'h10 |=> o_rd_data == 16'h0051)
        else $error("bad signature");
    AST_PRIMARY: assert property (q_rd && a == 8'h13 |=>
        o_rd_data[7:0] == PRIMARY_COMMAND_SET_CODE[7:0])
        else $error("bad command set low byte");
    AST_EXT_PTR: assert property (q_rd && a == 8'h15 ##1 q_rd && a == 8'h16 |=>
        o_rd_data == 16'h0001 && $past(o_rd_data) == 16'h000A)
        else $error("bad table pointer");
    AST_NO_ALT: assert property (q_rd && a inside {[8'h17:8'h1A]} |=>
        o_rd_data == 16'h0000)
        else $error("alternate fields not zero");
    AST_DENSITY: assert property (q_rd && a == 8'h20 |=>
        o_rd_data[7:0] == (LARGEST_DENSITY ? 8'h0B : 8'h0A))
        else $error("bad buffer write exponent");
    AST_UNMAPPED: assert property (q_rd && (a < 8'h10 || a >= 8'h27) |=>
        o_rd_data == 16'h0000)
        else $error("unmapped offset not zero");
    AST_ARRAY: assert property (i_rd_req && !i_query_mode |=>
        o_rd_data == $past(i_array_data))
        else $error("array data not passed");
    AST_HOLD: assert property (!i_rd_req |=> !o_rd_valid && $stable(o_rd_data))
        else $error("answer not held");
    AST_MODE_ON: assert property (i_query_mode |=> o_in_query)
        else $error("mode mirror not set");
    AST_MODE_OFF: assert property (!i_query_mode |=> !o_in_query)
        else $error("mode mirror not cleared");
    COV_QUERY: cover property (q_rd && a == 8'h10);
    COV_ARRAY: cover property (i_rd_req && !i_query_mode);
    COV_B2B: cover property (i_rd_req ##1 i_rd_req);
endmodule : cfq_readout_chk

bind cfq_readout cfq_readout_chk #(
    .PRIMARY_COMMAND_SET_CODE(PRIMARY_COMMAND_SET_CODE),
    .LARGEST_DENSITY(LARGEST_DENSITY)
) u_chk (.i_ref_clk, .i_rst, .i_query_mode, .i_rd_req, .i_word_addr,
    .i_array_data, .o_rd_data, .o_rd_valid, .o_in_query);

// file: verif/cfq_host_model.sv
/* cfq_host_model: bus controller issuing query reads.
   Assumes the answer shows one clock after each taken request. */
`timescale 1ns/1ps
module cfq_host_model
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rd_valid,
    input  wire logic [15:0] i_rd_data,
    output logic             o_query_mode = 1'b0,
    output logic             o_rd_req     = 1'b0,
    output logic [7:0]       o_word_addr  = 8'hA5
);
    logic [16:0] q [$]; // valid and data seen after each request
    logic [16:0] idle;  // first cycle after the burst ends
    // mode comes from the command decoder in practice
    task mode(input logic m);
        @(posedge i_ref_clk);
        #1;
        o_query_mode = m; // query command first
    endtask : mode
    // back-to-back reads, one word address a cycle
    task burst(input logic [7:0] a, input int n);
        q.delete();
        @(posedge i_ref_clk);
        #1;
        for (int k = 0; k < n; k++)
        begin
            o_rd_req    = 1'b1;
            o_word_addr = a + 8'(k); // plain word offsets
            @(posedge i_ref_clk);
            #1;
            q.push_back({i_rd_valid, i_rd_data});
        end
        o_rd_req    = 1'b0;
        o_word_addr = ~o_word_addr; // stale address must not linger
        @(posedge i_ref_clk);
        #1;
        idle = {i_rd_valid, i_rd_data};
    endtask : burst
endmodule : cfq_host_model

// file: verif/cfq_readout_test.sv
/* cfq_readout_test: self-checking bench of the query readout block.
   Assumes the host model drives requests and mode after each edge. */
`timescale 1ns/1ps
module cfq_readout_test;
    import cfq_pkg::*;
    localparam logic [15:0] PRI = 16'h5A3C; // arbitrary code
    localparam logic [7:0]  QMAP [16:38] = '{8'h51, 8'h52, 8'h59, PRI[7:0],
        PRI[15:8], 8'h0A, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h20,
        8'h85, 8'h95, 8'h06, 8'h0A, 8'h0A, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00};
    logic        i_ref_clk    = 1'b0;
    logic        i_rst        = 1'b1;
    logic [15:0] i_array_data = 16'h0000;
    logic        i_query_mode, i_rd_req, o_rd_valid, o_in_query;
    logic [7:0]  i_word_addr;
    logic [15:0] o_rd_data;
    int          err_count       = 0;
    int          samples_checked = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    cfq_readout #(.PRIMARY_COMMAND_SET_CODE(PRI), .LARGEST_DENSITY(1'b0)) dut
        (.i_ref_clk, .i_rst, .i_query_mode, .i_rd_req, .i_word_addr,
        .i_array_data, .o_rd_data, .o_rd_valid, .o_in_query);
    cfq_host_model host (.i_ref_clk, .i_rd_valid(o_rd_valid),
        .i_rd_data(o_rd_data), .o_query_mode(i_query_mode),
        .o_rd_req(i_rd_req), .o_word_addr(i_word_addr));
    task chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // whole id and system block in one back-to-back burst
    task t_map();
        host.mode(1'b1);
        host.burst(8'h10, 23);
        for (int k = 0; k < 23; k++)
            chk(host.q[k], {1'b1, 8'h00, QMAP[16 + k]});
        chk(host.idle, {1'b0, 8'h00, QMAP[38]}); // answer held after burst
    endtask : t_map
    // section edges: vendor area and geometry read zero here
    task t_unmapped();
        logic [7:0] lst [4] = '{8'h00, 8'h0F, 8'h27, 8'hFF};
        foreach (lst[k])
        begin
            host.burst(lst[k], 1);
            chk(host.q[0], {1'b1, 16'h0000});
        end
    endtask : t_unmapped
    // leaving and re-entering query mode
    task t_array();
        host.mode(1'b0);
        i_array_data = 16'hC3A5;
        host.burst(8'h10, 1);
        chk(host.q[0], {1'b1, 16'hC3A5});
        chk({16'h0000, o_in_query}, 17'h00000);
        host.mode(1'b1);
        host.burst(8'h10, 1);
        chk(host.q[0], {1'b1, 16'h0051});
        chk({16'h0000, o_in_query}, 17'h00001);
    endtask : t_array
    // reset in mid-run clears outputs, first read one cycle after release
    task t_reset();
        i_rst = 1'b1;
        #10;
        chk({o_rd_valid, o_rd_data}, 17'h00000);
        @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        host.burst(8'h12, 1);
        chk(host.q[0], {1'b1, 16'h0059});
    endtask : t_reset
    task end_sim();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (8) @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        t_map();
        t_unmapped();
        t_array();
        t_reset();
        end_sim();
    end
    // hang guard, far beyond the normal run
    initial
    begin
        #2000000;
        err_count++;
        end_sim();
    end
endmodule : cfq_readout_test
